/* hdl/fbs_slave.sv */
// application-layer state machine, process-data gating and status leds of the fieldbus slave
`timescale 1ns/100ps
`include "fbs_defs.svh"
module fbs_slave #(
  parameter int WORD_W      = `FBS_PDO_WORD_W,
  parameter int MAX_ENTRIES = `FBS_PDO_MAX_ENTRIES,
  parameter int FIFO_DEPTH  = `FBS_PDO_FIFO_DEPTH,
  parameter int TICK_CYCLES = `FBS_TICK_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        init_done,
  input  wire logic                        cfg_error,
  input  wire logic                        comm_timeout,
  input  wire logic                        req_valid,
  input  wire fbs_pkg::fbs_state_t         req_state,
  output logic                             req_accepted,
  output logic                             req_refused,
  output fbs_pkg::fbs_state_t              al_state,
  output logic                             mailbox_en,
  output logic                             input_update_en,
  output logic                             output_update_en,
  input  wire logic                        link_up_in,
  input  wire logic                        link_up_out,
  input  wire logic                        traffic_in,
  input  wire logic                        traffic_out,
  input  wire logic                        rx_valid,
  output logic                             rx_ready,
  input  wire logic [WORD_W-1:0]           rx_data,
  input  wire logic                        rx_from_in_port,
  input  wire logic                        sm2_event,
  input  wire logic [3:0]                  map_len,
  output logic [MAX_ENTRIES*WORD_W-1:0]    rx_objects,
  output logic [MAX_ENTRIES*16-1:0]        rx_object_index,
  output logic                             rx_objects_update,
  output logic                             led_run,
  output logic                             led_error,
  output logic                             led_link_in,
  output logic                             led_link_out
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int SW = $clog2(MAX_ENTRIES);

  // ------------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------------
  fbs_pkg::fbs_state_t state_ff;
  logic                switch_err_ff;
  logic                req_accepted_ff;
  logic                req_refused_ff;
  logic                legal_req;

  // a request for the current state is accepted as a no-op, except in boot, which refuses every request
  function automatic logic transition_ok(input fbs_pkg::fbs_state_t cur, input fbs_pkg::fbs_state_t tgt);
    logic ok;
    ok = 1'b0;
    unique case (cur)
      fbs_pkg::FBS_BOOT:   ok = 1'b0;
      fbs_pkg::FBS_INIT:   ok = (tgt == fbs_pkg::FBS_INIT) || (tgt == fbs_pkg::FBS_PREOP);
      fbs_pkg::FBS_PREOP:  ok = (tgt == fbs_pkg::FBS_INIT) || (tgt == fbs_pkg::FBS_PREOP) ||
                                (tgt == fbs_pkg::FBS_SAFEOP);
      fbs_pkg::FBS_SAFEOP: ok = (tgt != fbs_pkg::FBS_BOOT);
      fbs_pkg::FBS_OP:     ok = (tgt != fbs_pkg::FBS_BOOT);
      default:             ok = 1'b0;
    endcase
    transition_ok = ok;
  endfunction
  assign legal_req = transition_ok(state_ff, req_state);
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= fbs_pkg::FBS_BOOT;
    end else if (state_ff == fbs_pkg::FBS_BOOT) begin
      if (init_done) begin
        state_ff <= fbs_pkg::FBS_INIT;
      end
    end else if (req_valid && legal_req) begin
      state_ff <= req_state;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      switch_err_ff   <= 1'b0;
      req_accepted_ff <= 1'b0;
      req_refused_ff  <= 1'b0;
    end else begin
      req_accepted_ff <= req_valid && legal_req;
      req_refused_ff  <= req_valid && !legal_req;
      if (req_valid) begin
        switch_err_ff <= !legal_req;
      end
    end
  end
  assign req_accepted = req_accepted_ff;
  assign req_refused  = req_refused_ff;
  assign al_state     = state_ff;

  // ------------------------------------------------------------------
  // communication gating
  // ------------------------------------------------------------------
  // enables follow the state directly, so every exit path stops exactly what it must
  assign mailbox_en       = (state_ff == fbs_pkg::FBS_PREOP) || (state_ff == fbs_pkg::FBS_SAFEOP) ||
                            (state_ff == fbs_pkg::FBS_OP);
  assign input_update_en  = (state_ff == fbs_pkg::FBS_SAFEOP) || (state_ff == fbs_pkg::FBS_OP);
  assign output_update_en = (state_ff == fbs_pkg::FBS_OP);

  // ------------------------------------------------------------------
  // receive process data path
  // ------------------------------------------------------------------
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic              rx_take;
  logic              drain_ff;
  logic [SW-1:0]     slot_ff;
  logic [SW-1:0]     last_slot;
  logic              update_ff;
  logic [WORD_W-1:0] obj_ff [MAX_ENTRIES];

  // words arriving on the OUT side or outside operational are discarded, never stalled
  assign rx_take       = rx_from_in_port && output_update_en;
  assign fifo_in_valid = rx_valid && rx_take;
  assign rx_ready      = rx_take ? fifo_in_ready : 1'b1;
  assign fifo_pop      = drain_ff && fifo_out_valid;

  // an empty or oversized mapping length is clamped into the usable slot range
  assign last_slot = (map_len == 4'h0) ? '0 :
                     (32'(map_len) > MAX_ENTRIES) ? SW'(MAX_ENTRIES - 1) : SW'(map_len - 4'h1);
  fbs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .flush     (!output_update_en),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ff),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge mclk) begin
    if (reset || !output_update_en) begin
      drain_ff  <= 1'b0;
      slot_ff   <= '0;
      update_ff <= 1'b0;
    end else begin
      update_ff <= fifo_pop && (slot_ff == last_slot);
      if (!drain_ff && sm2_event) begin
        drain_ff <= 1'b1;
      end else if (fifo_pop) begin
        drain_ff <= (slot_ff != last_slot);
        slot_ff  <= (slot_ff == last_slot) ? '0 : slot_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < MAX_ENTRIES; i++) begin
        obj_ff[i] <= '0;
      end
    end else if (fifo_pop && output_update_en) begin
      obj_ff[slot_ff] <= fifo_out_data;
    end
  end

  // default object index of each slot at the default mapping length; at any other length, and in slots past it, the index is none
  function automatic logic [15:0] default_index(input int slot);
    unique case (slot)
      0:       default_index = `FBS_OBJ_CTRL_WORD;
      1:       default_index = `FBS_OBJ_VL_TARGET;
      2:       default_index = `FBS_OBJ_OP_MODE;
      3:       default_index = `FBS_OBJ_MAX_TORQUE;
      4:       default_index = `FBS_OBJ_MAX_SPEED;
      default: default_index = `FBS_OBJ_UNMAPPED;
    endcase
  endfunction

  for (genvar g = 0; g < MAX_ENTRIES; g++) begin : g_obj
    assign rx_objects[g*WORD_W +: WORD_W] = obj_ff[g];
    assign rx_object_index[g*16 +: 16]    = (map_len == `FBS_DEFAULT_MAP_LEN) ? default_index(g) :
                                            `FBS_OBJ_UNMAPPED;
  end

  assign rx_objects_update = update_ff;

  // ------------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------------
  logic [TW-1:0] tick_cnt_ff;
  logic          ms_tick_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_ff <= '0;
      ms_tick_ff  <= 1'b0;
    end else if (tick_cnt_ff == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      ms_tick_ff  <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      ms_tick_ff  <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // run and error leds
  // ------------------------------------------------------------------
  fbs_pkg::fbs_run_pat_t run_pat;
  fbs_pkg::fbs_run_pat_t run_pat_ff;
  fbs_pkg::fbs_err_pat_t err_pat;
  fbs_pkg::fbs_err_pat_t err_pat_ff;
  logic [10:0]           run_ph_ff;
  logic [10:0]           err_ph_ff;
  logic [10:0]           err_period;
  logic                  led_run_ff;
  logic                  led_error_ff;

  assign run_pat = (state_ff == fbs_pkg::FBS_OP)    ? fbs_pkg::FBS_RUN_ON :
                   (state_ff == fbs_pkg::FBS_PREOP) ? fbs_pkg::FBS_RUN_BLINK : fbs_pkg::FBS_RUN_OFF;
  // configuration fault outranks a switching fault, which outranks a timeout
  assign err_pat = cfg_error     ? fbs_pkg::FBS_ERR_CONFIG :
                   switch_err_ff ? fbs_pkg::FBS_ERR_SWITCH :
                   comm_timeout  ? fbs_pkg::FBS_ERR_TIMEOUT : fbs_pkg::FBS_ERR_NONE;
  always_comb begin
    unique case (err_pat_ff)
      fbs_pkg::FBS_ERR_SWITCH:  err_period = `FBS_FLASH_ON_MS + `FBS_LONG_OFF_MS;
      fbs_pkg::FBS_ERR_TIMEOUT: err_period = (`FBS_FLASH_ON_MS + `FBS_FLASH_OFF_MS) << 1;
      default:                  err_period = `FBS_FLASH_ON_MS + `FBS_FLASH_OFF_MS;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      run_pat_ff <= fbs_pkg::FBS_RUN_OFF;
      run_ph_ff  <= `FBS_PHASE_ZERO;
    end else if (run_pat != run_pat_ff) begin
      run_pat_ff <= run_pat;
      run_ph_ff  <= `FBS_PHASE_ZERO;
    end else if (ms_tick_ff) begin
      run_ph_ff <= (run_ph_ff == `FBS_FLASH_ON_MS + `FBS_FLASH_OFF_MS - `FBS_PHASE_STEP) ?
                   `FBS_PHASE_ZERO : run_ph_ff + `FBS_PHASE_STEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      err_pat_ff <= fbs_pkg::FBS_ERR_NONE;
      err_ph_ff  <= `FBS_PHASE_ZERO;
    end else if (err_pat != err_pat_ff) begin
      err_pat_ff <= err_pat;
      err_ph_ff  <= `FBS_PHASE_ZERO;
    end else if (ms_tick_ff) begin
      err_ph_ff <= (err_ph_ff == err_period - `FBS_PHASE_STEP) ? `FBS_PHASE_ZERO : err_ph_ff + `FBS_PHASE_STEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      led_run_ff   <= 1'b0;
      led_error_ff <= 1'b0;
    end else begin
      led_run_ff <= (run_pat_ff == fbs_pkg::FBS_RUN_ON) ||
                    ((run_pat_ff == fbs_pkg::FBS_RUN_BLINK) && (run_ph_ff < `FBS_FLASH_ON_MS));
      unique case (err_pat_ff)
        fbs_pkg::FBS_ERR_NONE:    led_error_ff <= 1'b0;
        fbs_pkg::FBS_ERR_TIMEOUT: led_error_ff <= (err_ph_ff < `FBS_FLASH_ON_MS) ||
                                                  ((err_ph_ff >= `FBS_FLASH_ON_MS + `FBS_FLASH_OFF_MS) &&
                                                   (err_ph_ff < (`FBS_FLASH_ON_MS << 1) + `FBS_FLASH_OFF_MS));
        default:                  led_error_ff <= (err_ph_ff < `FBS_FLASH_ON_MS);
      endcase
    end
  end

  assign led_run   = led_run_ff;
  assign led_error = led_error_ff;

  // ------------------------------------------------------------------
  // link leds
  // ------------------------------------------------------------------
  logic [10:0] link_ph_ff;
  logic [10:0] hold_in_ff;
  logic [10:0] hold_out_ff;
  logic        led_link_in_ff;
  logic        led_link_out_ff;
  logic        flash_on;

  // a short traffic burst keeps the led flashing for the hold time so it stays visible
  function automatic logic [10:0] hold_next(input logic [10:0] h, input logic act, input logic tick);
    hold_next = act ? `FBS_LINK_HOLD_MS : (tick && h != `FBS_PHASE_ZERO) ? h - `FBS_PHASE_STEP : h;
  endfunction
  assign flash_on = (link_ph_ff < `FBS_LINK_FLASH_MS);
  always_ff @(posedge mclk) begin
    if (reset) begin
      link_ph_ff      <= `FBS_PHASE_ZERO;
      hold_in_ff      <= `FBS_PHASE_ZERO;
      hold_out_ff     <= `FBS_PHASE_ZERO;
      led_link_in_ff  <= 1'b0;
      led_link_out_ff <= 1'b0;
    end else begin
      if (ms_tick_ff) begin
        link_ph_ff <= (link_ph_ff == (`FBS_LINK_FLASH_MS << 1) - `FBS_PHASE_STEP) ?
                      `FBS_PHASE_ZERO : link_ph_ff + `FBS_PHASE_STEP;
      end
      hold_in_ff      <= hold_next(hold_in_ff, traffic_in && link_up_in, ms_tick_ff);
      hold_out_ff     <= hold_next(hold_out_ff, traffic_out && link_up_out, ms_tick_ff);
      led_link_in_ff  <= link_up_in && ((hold_in_ff == `FBS_PHASE_ZERO) || flash_on);
      led_link_out_ff <= link_up_out && ((hold_out_ff == `FBS_PHASE_ZERO) || flash_on);
    end
  end

  assign led_link_in  = led_link_in_ff;
  assign led_link_out = led_link_out_ff;

endmodule

/* pkg/fbs_defs.svh */
// timing figures and fixed values of the fieldbus slave state block
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// clock period and millisecond tick
`define FBS_CLK_PERIOD_PS   5000
`define FBS_TICK_PERIOD_PS  1000000000
`define FBS_TICK_CYCLES     (`FBS_TICK_PERIOD_PS / `FBS_CLK_PERIOD_PS)

// led phase lengths in milliseconds
`define FBS_FLASH_ON_MS     11'h0c8
`define FBS_FLASH_OFF_MS    11'h0c8
`define FBS_LONG_OFF_MS     11'h3e8
`define FBS_LINK_FLASH_MS   11'h032
`define FBS_LINK_HOLD_MS    11'h064
`define FBS_PHASE_ZERO      11'h000
`define FBS_PHASE_STEP      11'h001

// process data layout
`define FBS_PDO_WORD_W      32
`define FBS_PDO_MAX_ENTRIES 8
`define FBS_PDO_FIFO_DEPTH  16
`define FBS_DEFAULT_MAP_LEN 4'h5

// object index of each default receive mapping slot
`define FBS_OBJ_CTRL_WORD   16'h6040
`define FBS_OBJ_VL_TARGET   16'h6042
`define FBS_OBJ_OP_MODE     16'h6060
`define FBS_OBJ_MAX_TORQUE  16'h6072
`define FBS_OBJ_MAX_SPEED   16'h6080
`define FBS_OBJ_UNMAPPED    16'h0000

`endif

/* pkg/fbs_pkg.sv */
// types of the fieldbus slave state block
package fbs_pkg;

  typedef enum logic [2:0] {
    FBS_BOOT   = 3'h0,
    FBS_INIT   = 3'h1,
    FBS_PREOP  = 3'h2,
    FBS_SAFEOP = 3'h3,
    FBS_OP     = 3'h4
  } fbs_state_t;

  typedef enum logic [1:0] {
    FBS_ERR_NONE    = 2'h0,
    FBS_ERR_CONFIG  = 2'h1,
    FBS_ERR_SWITCH  = 2'h2,
    FBS_ERR_TIMEOUT = 2'h3
  } fbs_err_pat_t;

  typedef enum logic [1:0] {
    FBS_RUN_OFF   = 2'h0,
    FBS_RUN_BLINK = 2'h1,
    FBS_RUN_ON    = 2'h2
  } fbs_run_pat_t;

endpackage

/* hdl/fbs_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module fbs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;
  assign out_data  = mem_ff[rd_ptr_ff];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wrap_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= wrap_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

/* dv/fbs_slave_asserts.sv */
// concurrent checks on the ports of the fieldbus slave state block
`timescale 1ns/100ps
module fbs_slave_chk (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                init_done,
  input wire logic                req_valid,
  input wire fbs_pkg::fbs_state_t req_state,
  input wire logic                req_accepted,
  input wire logic                req_refused,
  input wire fbs_pkg::fbs_state_t al_state,
  input wire logic                mailbox_en,
  input wire logic                input_update_en,
  input wire logic                output_update_en,
  input wire logic                rx_ready,
  input wire logic                rx_objects_update,
  input wire logic                led_run,
  input wire logic                link_up_in,
  input wire logic                led_link_in
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // --------------------------------
  // states, answers, gating and leds
  // --------------------------------
  a_boot_to_init: assert property (
    !$past(reset) && al_state == fbs_pkg::FBS_BOOT && init_done |=> al_state == fbs_pkg::FBS_INIT)
    else $error("boot did not move to init");
  a_boot_refused: assert property (
    !$past(reset) && al_state == fbs_pkg::FBS_BOOT && req_valid |=> req_refused)
    else $error("request in boot not refused");
  a_undef_refused: assert property (
    req_valid && al_state == fbs_pkg::FBS_INIT && req_state inside {fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_OP}
    |=> req_refused && !req_accepted && $stable(al_state)) else $error("undefined transition taken");
  a_preop_safeop: assert property (
    req_valid && al_state == fbs_pkg::FBS_PREOP && req_state == fbs_pkg::FBS_SAFEOP
    |=> req_accepted && al_state == fbs_pkg::FBS_SAFEOP) else $error("pre-op to safe-op not taken");
  a_answer_cause: assert property ((req_accepted || req_refused) |-> $past(req_valid))
    else $error("answer without request");
  a_mailbox_gate: assert property (
    mailbox_en == (al_state inside {fbs_pkg::FBS_PREOP, fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_OP}))
    else $error("mailbox enable wrong for state");
  a_input_gate: assert property (
    input_update_en == (al_state inside {fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_OP}))
    else $error("input enable wrong for state");
  a_output_gate: assert property (output_update_en == (al_state == fbs_pkg::FBS_OP))
    else $error("output enable wrong for state");
  a_ready_drop: assert property (al_state != fbs_pkg::FBS_OP |-> rx_ready)
    else $error("back-pressure outside operational");
  a_update_in_op: assert property (rx_objects_update |-> $past(output_update_en))
    else $error("outputs applied outside operational");
  a_run_steady: assert property (al_state == fbs_pkg::FBS_OP [*3] |-> led_run)
    else $error("run led not steady in operational");
  a_link_dark: assert property (!link_up_in [*3] |-> !led_link_in)
    else $error("link led lit without link");
  c_frame: cover property (rx_objects_update);
  c_refuse: cover property (req_refused);
  c_to_op: cover property (req_accepted && al_state == fbs_pkg::FBS_OP);
endmodule

bind fbs_slave fbs_slave_chk u_chk (.mclk(mclk), .reset(reset), .init_done(init_done), .req_valid(req_valid),
  .req_state(req_state), .req_accepted(req_accepted), .req_refused(req_refused), .al_state(al_state),
  .mailbox_en(mailbox_en), .input_update_en(input_update_en), .output_update_en(output_update_en),
  .rx_ready(rx_ready), .rx_objects_update(rx_objects_update), .led_run(led_run), .link_up_in(link_up_in),
  .led_link_in(led_link_in));

/* dv/fbs_master_model.sv */
// network master model: offers output process-data words and sync-manager events
`timescale 1ns/100ps
module fbs_master_model (
  input wire logic   mclk,
  input wire logic   rx_ready,
  output logic        rx_valid,
  output logic [31:0] rx_data,
  output logic        rx_from_in_port,
  output logic        sm2_event
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 32'h0;
    rx_from_in_port = 1'b1;
    sm2_event = 1'b0;
  end
  // words go out strictly in order and each is held until the edge that takes it
  task automatic send(input int n, input logic [31:0] base, input logic from_in, input int gap);
    logic ok;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data = base + i;
      rx_from_in_port = from_in;
      do begin
        ok = rx_ready;
        @(negedge mclk);
      end while (!ok);
      // the last word leaves one idle edge so a following call never re-raises valid in the same step
      if (gap > 0 || i == n - 1) begin
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        repeat (i == n - 1 ? 1 : gap) @(negedge mclk);
      end
    end
  endtask
  task automatic sm2();
    sm2_event = 1'b1;
    @(negedge mclk);
    sm2_event = 1'b0;
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench of the fieldbus slave state block
`timescale 1ns/100ps
module testbench;
  localparam int TK = 10;
  logic mclk, reset, init_done, cfg_error, comm_timeout, req_valid, req_accepted, req_refused;
  fbs_pkg::fbs_state_t req_state, al_state;
  logic mailbox_en, input_update_en, output_update_en, link_up_in, link_up_out, traffic_in, traffic_out;
  logic rx_valid, rx_ready, rx_from_in_port, sm2_event, rx_objects_update;
  logic led_run, led_error, led_link_in, led_link_out;
  logic [31:0] rx_data;
  logic [3:0] map_len;
  logic [255:0] rx_objects;
  logic [127:0] rx_object_index;
  int errors = 0, check_count = 0, cycles = 0;
  fbs_slave #(.TICK_CYCLES(TK)) DUT (.mclk(mclk), .reset(reset), .init_done(init_done), .cfg_error(cfg_error),
    .comm_timeout(comm_timeout), .req_valid(req_valid), .req_state(req_state), .req_accepted(req_accepted),
    .req_refused(req_refused), .al_state(al_state), .mailbox_en(mailbox_en), .input_update_en(input_update_en),
    .output_update_en(output_update_en), .link_up_in(link_up_in), .link_up_out(link_up_out),
    .traffic_in(traffic_in), .traffic_out(traffic_out), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_from_in_port(rx_from_in_port), .sm2_event(sm2_event), .map_len(map_len),
    .rx_objects(rx_objects), .rx_object_index(rx_object_index), .rx_objects_update(rx_objects_update),
    .led_run(led_run), .led_error(led_error), .led_link_in(led_link_in), .led_link_out(led_link_out));
  fbs_master_model m (.mclk(mclk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_from_in_port(rx_from_in_port), .sm2_event(sm2_event));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ----------------------
  // shared helpers
  // ----------------------
  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      $display("[FAIL] run ceiling expected done seen hang");
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // led phases may shift by up to two ticks against the tick divider
  task automatic near(input string what, input int exp, input int got);
    check_count++;
    if (got > exp + 2 * TK || got + 2 * TK < exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  function automatic logic led(input int w);
    case (w)
      0: return led_run;
      1: return led_error;
      2: return led_link_in;
      default: return led_link_out;
    endcase
  endfunction
  function automatic logic legal(input fbs_pkg::fbs_state_t f, input fbs_pkg::fbs_state_t t);
    if (f == fbs_pkg::FBS_BOOT || t == fbs_pkg::FBS_BOOT) return 1'b0;
    if (f == fbs_pkg::FBS_INIT && t > fbs_pkg::FBS_PREOP) return 1'b0;
    return !(f == fbs_pkg::FBS_PREOP && t == fbs_pkg::FBS_OP);
  endfunction
  task automatic req(input fbs_pkg::fbs_state_t s);
    fbs_pkg::fbs_state_t exp;
    logic acc;
    @(negedge mclk);
    acc = legal(al_state, s);
    exp = acc ? s : al_state;
    req_valid = 1'b1;
    req_state = s;
    @(negedge mclk);
    req_valid = 1'b0;
    chk("accepted", {31'h0, acc}, {31'h0, req_accepted});
    chk("refused", {31'h0, !acc}, {31'h0, req_refused});
    chk("state", {29'h0, exp}, {29'h0, al_state});
    chk("mailbox", {31'h0, exp > fbs_pkg::FBS_INIT}, {31'h0, mailbox_en});
    chk("inputs", {31'h0, exp > fbs_pkg::FBS_PREOP}, {31'h0, input_update_en});
    chk("outputs", {31'h0, exp == fbs_pkg::FBS_OP}, {31'h0, output_update_en});
  endtask
  task automatic blink(input int w, input int on_c, input int off_c);
    int n;
    n = 0;
    while (led(w) !== 1'b1 && n < 3) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (led(w) === 1'b1 && n < 12000) begin
      @(negedge mclk);
      n++;
    end
    near("led on", on_c, n);
    n = 0;
    while (led(w) === 1'b0 && n < 12000) begin
      @(negedge mclk);
      n++;
    end
    near("led off", off_c, n);
  endtask
  task automatic wait_upd();
    int n;
    n = 0;
    while (rx_objects_update !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("update", 32'h1, {31'h0, rx_objects_update});
  endtask
  // ----------------------
  // scenarios
  // ----------------------
  task automatic t_leds();
    req(fbs_pkg::FBS_PREOP);
    blink(0, 2000, 2000);
    req(fbs_pkg::FBS_OP);
    blink(1, 2000, 10000);
    req(fbs_pkg::FBS_PREOP);
    cfg_error = 1'b1;
    blink(1, 2000, 2000);
    cfg_error = 1'b0;
    comm_timeout = 1'b1;
    blink(1, 2000, 2000);
    blink(1, 2000, 2000);
    comm_timeout = 1'b0;
    repeat (3) @(negedge mclk);
    chk("error led", 32'h0, {31'h0, led_error});
  endtask
  task automatic t_link(input int w);
    int n;
    if (w == 2) link_up_in = 1'b1;
    else link_up_out = 1'b1;
    repeat (3) @(negedge mclk);
    chk("link on", 32'h1, {31'h0, led(w)});
    if (w == 2) traffic_in = 1'b1;
    else traffic_out = 1'b1;
    @(negedge mclk);
    traffic_in = 1'b0;
    traffic_out = 1'b0;
    n = 0;
    repeat (1000) begin
      @(negedge mclk);
      n += (led(w) === 1'b0);
    end
    near("link flash", 500, n);
    repeat (200) @(negedge mclk);
    chk("link hold", 32'h1, {31'h0, led(w)});
    link_up_in = 1'b0;
    link_up_out = 1'b0;
    repeat (3) @(negedge mclk);
    chk("link off", 32'h0, {31'h0, led(w)});
  endtask
  task automatic t_frames();
    logic [15:0] idx [5] = '{16'h6040, 16'h6042, 16'h6060, 16'h6072, 16'h6080};
    map_len = 4'h5;
    m.sm2();
    m.send(5, 32'h100, 1'b1, 2);
    wait_upd();
    for (int i = 0; i < 8; i++) chk("index", {16'h0, i < 5 ? idx[i] : 16'h0}, {16'h0, rx_object_index[i*16+:16]});
    for (int i = 0; i < 5; i++) chk("slot", 32'h100 + i, rx_objects[i*32+:32]);
    map_len = 4'h1;
    m.send(1, 32'h200, 1'b0, 0);
    m.send(1, 32'h300, 1'b1, 0);
    m.sm2();
    wait_upd();
    chk("remap slot", 32'h300, rx_objects[31:0]);
    chk("remap index", 32'h0, {16'h0, rx_object_index[15:0]});
    map_len = 4'h8;
    m.send(16, 32'h400, 1'b1, 0);
    chk("fifo full", 32'h0, {31'h0, rx_ready});
    for (int f = 0; f < 2; f++) begin
      m.sm2();
      wait_upd();
      for (int i = 0; i < 8; i++) chk("drain", 32'h400 + f * 8 + i, rx_objects[i*32+:32]);
    end
    chk("fifo empty", 32'h1, {31'h0, rx_ready});
  endtask
  initial begin
    automatic fbs_pkg::fbs_state_t walk [13] = '{fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_OP, fbs_pkg::FBS_PREOP,
      fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_INIT, fbs_pkg::FBS_SAFEOP, fbs_pkg::FBS_PREOP, fbs_pkg::FBS_SAFEOP,
      fbs_pkg::FBS_OP, fbs_pkg::FBS_INIT, fbs_pkg::FBS_OP, fbs_pkg::FBS_BOOT, fbs_pkg::FBS_INIT};
    reset = 1'b1;
    {init_done, cfg_error, comm_timeout, req_valid, link_up_in, link_up_out, traffic_in, traffic_out} = 8'h0;
    req_state = fbs_pkg::FBS_INIT;
    map_len = 4'h5;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    req(fbs_pkg::FBS_PREOP);
    init_done = 1'b1;
    repeat (2) @(negedge mclk);
    chk("init entry", {29'h0, fbs_pkg::FBS_INIT}, {29'h0, al_state});
    t_leds();
    t_link(2);
    t_link(3);
    req(fbs_pkg::FBS_SAFEOP);
    repeat (3) @(negedge mclk);
    chk("run safe-op", 32'h0, {31'h0, led_run});
    req(fbs_pkg::FBS_OP);
    repeat (3) @(negedge mclk);
    chk("run op", 32'h1, {31'h0, led_run});
    t_frames();
    for (int i = 0; i < 13; i++) req(walk[i]);
    end_sim();
  end
endmodule
